// ---- verilog/stack_exchange_pkg.sv ----
/*
  Constants, types and timing tables for the stack and exchange execution unit.
  Assumes one clock state of the instruction timing per ref_clk cycle.
*/
// Overview of operation
// - DD E5 pushes first index, high first.
// - FD E5 pushes second index identically.
// - Index push takes 4,5,3,3 states.
// - Stack pointer addresses every stack transfer.
// - Pair pop: low byte, increment, high, increment.
// - Pair field: 00,01,10 general, 11 accumulator-flags.
// - Pair pop takes 4,3,3 states.
// - DD E1 pops first index, low first.
// - FD E1 pops second index identically.
// - Index pop takes 4,4,3,3 states.
// - Only 08 and the accumulator-flags pair pop alter flags.
// - EB swaps second and third pairs.
// - 08 swaps accumulator-flags with alternate copy.
// - Bank swap exchanges three pairs with alternates.
// - Register swaps take one 4-state cycle.
// - E3 swaps third pair with stack top.
// - Stack-top swap takes 4,3,4,3,5 states.
// - Pair push: decrement, high, decrement, low; 5,3,3.
package stack_exchange_pkg;

  // ----------------------------------------------------------------
  // Opcode bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] PREFIX_FIRST_INDEX  = 8'hdd;
  localparam logic [7:0] PREFIX_SECOND_INDEX = 8'hfd;
  localparam logic [7:0] OPC_PUSH_INDEX      = 8'he5;
  localparam logic [7:0] OPC_POP_INDEX       = 8'he1;
  localparam logic [7:0] OPC_SWAP_DE_HL      = 8'heb;
  localparam logic [7:0] OPC_SWAP_AF         = 8'h08;
  localparam logic [7:0] OPC_BANK_SWAP       = 8'hd9;
  localparam logic [7:0] OPC_SWAP_SP_HL      = 8'he3;
  localparam logic [7:0] PAIR_OP_MASK        = 8'hcf;
  localparam logic [7:0] OPC_PUSH_PAIR       = 8'hc5;
  localparam logic [7:0] OPC_POP_PAIR        = 8'hc1;
  localparam int         PAIR_FIELD_LSB      = 4;

  localparam logic [1:0] SEL_FIRST  = 2'b00;
  localparam logic [1:0] SEL_SECOND = 2'b01;
  localparam logic [1:0] SEL_THIRD  = 2'b10;
  localparam logic [1:0] SEL_ACCUM  = 2'b11;

  // ----------------------------------------------------------------
  // Machine cycle lengths in clock states, entry m at bits [3m+2:3m]
  // ----------------------------------------------------------------
  localparam logic [14:0] MLEN_PUSH_PAIR  = {3'd0, 3'd0, 3'd3, 3'd3, 3'd5};
  localparam logic [14:0] MLEN_PUSH_INDEX = {3'd0, 3'd3, 3'd3, 3'd5, 3'd4};
  localparam logic [14:0] MLEN_POP_PAIR   = {3'd0, 3'd0, 3'd3, 3'd3, 3'd4};
  localparam logic [14:0] MLEN_POP_INDEX  = {3'd0, 3'd3, 3'd3, 3'd4, 3'd4};
  localparam logic [14:0] MLEN_REG_SWAP   = {3'd0, 3'd0, 3'd0, 3'd0, 3'd4};
  localparam logic [14:0] MLEN_SWAP_SP_HL = {3'd5, 3'd3, 3'd4, 3'd3, 3'd4};
  localparam logic [2:0]  MCNT_PAIR_STACK  = 3'd3;
  localparam logic [2:0]  MCNT_INDEX_STACK = 3'd4;
  localparam logic [2:0]  MCNT_REG_SWAP    = 3'd1;
  localparam logic [2:0]  MCNT_SWAP_SP_HL  = 3'd5;

  // Stack pointer offsets and steps as two-bit signed codes.
  localparam logic [1:0] OFS_ZERO  = 2'b00;
  localparam logic [1:0] OFS_PLUS  = 2'b01;
  localparam logic [1:0] OFS_MINUS = 2'b11;

  localparam logic [15:0] REG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    op_none, op_push_pair, op_push_ix, op_push_iy, op_pop_pair, op_pop_ix,
    op_pop_iy, op_swap_de_hl, op_swap_af, op_bank_swap, op_swap_sp_hl
  } op_t;

  typedef enum logic {st_idle = 1'b0, st_run = 1'b1} exec_state_t;

  typedef struct packed {
    logic [15:0] first_general_pair;
    logic [15:0] second_general_pair;
    logic [15:0] third_general_pair;
    logic [15:0] accum_flags_pair;
    logic [15:0] alternate_first_pair;
    logic [15:0] alternate_second_pair;
    logic [15:0] alternate_third_pair;
    logic [15:0] alternate_accum_flags_pair;
    logic [15:0] first_index_register;
    logic [15:0] second_index_register;
    logic [15:0] stack_pointer;
  } regs_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        rd;
    logic        wr;
  } mem_req_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       hi;
    logic [1:0] ofs;
    logic [1:0] step;
  } access_t;

endpackage

// ---- verilog/stack_and_exchange_exec.sv ----
/*
  Execution unit for stack store, stack load and exchange instructions.
  Assumes the caller presents the whole opcode with start while idle and
  that memory answers a read by the last clock state of the read cycle.
*/
`timescale 1ns/1ps
module stack_and_exchange_exec
  import stack_exchange_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Instruction request
  input  wire logic       start,
  input  wire logic [7:0] prefix,
  input  wire logic [7:0] opcode,
  // Register file preload
  input  wire logic       load_en,
  input  wire regs_t      load_value,
  // Memory bus
  input  wire logic [7:0] mem_rdata,
  output mem_req_t        mem,
  // Status and register file
  output regs_t           regs,
  output logic            busy,
  output logic            done
);

  // ----------------------------------------------------------------
  // Decode and tables
  // ----------------------------------------------------------------
  function automatic op_t decode(input logic [7:0] pre, input logic [7:0] opc);
    op_t r;
    r = op_none;
    if (pre == PREFIX_FIRST_INDEX || pre == PREFIX_SECOND_INDEX) begin
      if (opc == OPC_PUSH_INDEX) begin
        r = (pre == PREFIX_FIRST_INDEX) ? op_push_ix : op_push_iy;
      end else if (opc == OPC_POP_INDEX) begin
        r = (pre == PREFIX_FIRST_INDEX) ? op_pop_ix : op_pop_iy;
      end
    end else if ((opc & PAIR_OP_MASK) == OPC_PUSH_PAIR) begin
      r = op_push_pair;
    end else if ((opc & PAIR_OP_MASK) == OPC_POP_PAIR) begin
      r = op_pop_pair;
    end else if (opc == OPC_SWAP_DE_HL) begin
      r = op_swap_de_hl;
    end else if (opc == OPC_SWAP_AF) begin
      r = op_swap_af;
    end else if (opc == OPC_BANK_SWAP) begin
      r = op_bank_swap;
    end else if (opc == OPC_SWAP_SP_HL) begin
      r = op_swap_sp_hl;
    end
    return r;
  endfunction

  function automatic logic [14:0] mlen_table(input op_t o);
    case (o)
      op_push_pair:             mlen_table = MLEN_PUSH_PAIR;
      op_push_ix, op_push_iy:   mlen_table = MLEN_PUSH_INDEX;
      op_pop_pair:              mlen_table = MLEN_POP_PAIR;
      op_pop_ix, op_pop_iy:     mlen_table = MLEN_POP_INDEX;
      op_swap_sp_hl:            mlen_table = MLEN_SWAP_SP_HL;
      default:                  mlen_table = MLEN_REG_SWAP;
    endcase
  endfunction

  function automatic logic [2:0] mcount(input op_t o);
    case (o)
      op_push_pair, op_pop_pair:                   mcount = MCNT_PAIR_STACK;
      op_push_ix, op_push_iy, op_pop_ix, op_pop_iy: mcount = MCNT_INDEX_STACK;
      op_swap_sp_hl:                               mcount = MCNT_SWAP_SP_HL;
      default:                                     mcount = MCNT_REG_SWAP;
    endcase
  endfunction

  // Memory access of machine cycle m; the index forms spend one extra
  // opcode cycle before the first transfer.
  function automatic access_t access(input op_t o, input logic [2:0] m);
    access_t a;
    logic [2:0] k;
    a = '0;
    k = m;
    if (o == op_push_ix || o == op_push_iy || o == op_pop_ix || o == op_pop_iy) begin
      k = m - 3'd1;
    end
    case (o)
      op_push_pair, op_push_ix, op_push_iy: begin
        if (k == 3'd1 || k == 3'd2) begin
          a.wr   = 1'b1;
          a.hi   = (k == 3'd1);
          a.ofs  = OFS_MINUS;
          a.step = OFS_MINUS;
        end
      end
      op_pop_pair, op_pop_ix, op_pop_iy: begin
        if (k == 3'd1 || k == 3'd2) begin
          a.rd   = 1'b1;
          a.hi   = (k == 3'd2);
          a.ofs  = OFS_ZERO;
          a.step = OFS_PLUS;
        end
      end
      op_swap_sp_hl: begin
        if (k != 3'd0) begin
          a.rd  = (k == 3'd1 || k == 3'd2);
          a.wr  = (k == 3'd3 || k == 3'd4);
          a.hi  = (k == 3'd2 || k == 3'd3);
          a.ofs = a.hi ? OFS_PLUS : OFS_ZERO;
        end
      end
      default: a = '0;
    endcase
    return a;
  endfunction

  function automatic logic [15:0] get_pair(input regs_t r, input logic [1:0] s);
    case (s)
      SEL_FIRST:  get_pair = r.first_general_pair;
      SEL_SECOND: get_pair = r.second_general_pair;
      SEL_THIRD:  get_pair = r.third_general_pair;
      default:    get_pair = r.accum_flags_pair;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  exec_state_t state, next_state;
  op_t         op, next_op;
  logic [1:0]  pair_sel, next_pair_sel;
  logic [2:0]  mcyc, next_mcyc;
  logic [2:0]  tst, next_tst;
  logic [15:0] tmp, next_tmp;
  regs_t       next_regs;
  mem_req_t    next_mem;
  logic        next_busy;
  logic        next_done;

  access_t     acc;
  access_t     acc_next;
  logic [14:0] mlens;
  logic [2:0]  cur_len;
  logic [15:0] src;

  // ----------------------------------------------------------------
  // Per-cycle lookups
  // ----------------------------------------------------------------
  // Kept apart from the sequencer so the tables stay a pure decode of op.
  always_comb begin
    acc      = access(op, mcyc);
    acc_next = access(op, mcyc + 3'd1);
    mlens    = mlen_table(op);
    cur_len  = mlens[3*mcyc +: 3];
    case (op)
      op_push_ix:    src = regs.first_index_register;
      op_push_iy:    src = regs.second_index_register;
      op_swap_sp_hl: src = regs.third_general_pair;
      default:       src = get_pair(regs, pair_sel);
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state    = state;
    next_op       = op;
    next_pair_sel = pair_sel;
    next_mcyc     = mcyc;
    next_tst      = tst;
    next_tmp      = tmp;
    next_regs     = regs;
    next_mem      = mem;
    next_busy     = busy;
    next_done     = 1'b0;
    case (state)
      st_idle: begin
        if (start && decode(prefix, opcode) != op_none) begin
          next_op       = decode(prefix, opcode);
          next_pair_sel = opcode[PAIR_FIELD_LSB +: 2];
          next_mcyc     = 3'd0;
          next_tst      = 3'd0;
          next_state    = st_run;
          next_busy     = 1'b1;
        end else if (load_en) begin
          next_regs = load_value;
        end
      end
      st_run: begin
        if (tst != cur_len - 3'd1) begin
          next_tst = tst + 3'd1;
        end else begin
          if (acc.rd) begin
            if (acc.hi) begin
              next_tmp[15:8] = mem_rdata;
            end else begin
              next_tmp[7:0] = mem_rdata;
            end
          end
          // Address arithmetic is 16 bits wide, so it wraps.
          next_regs.stack_pointer = regs.stack_pointer + {{14{acc.step[1]}}, acc.step};
          next_mem.rd = 1'b0;
          next_mem.wr = 1'b0;
          if (mcyc == mcount(op) - 3'd1) begin
            next_state = st_idle;
            next_busy  = 1'b0;
            next_done  = 1'b1;
            // Only the accumulator-flags swap and the accumulator-flags pop touch the flags register.
            case (op)
              op_pop_pair: begin
                case (pair_sel)
                  SEL_FIRST:  next_regs.first_general_pair  = next_tmp;
                  SEL_SECOND: next_regs.second_general_pair = next_tmp;
                  SEL_THIRD:  next_regs.third_general_pair  = next_tmp;
                  default:    next_regs.accum_flags_pair    = next_tmp;
                endcase
              end
              op_pop_ix:     next_regs.first_index_register  = next_tmp;
              op_pop_iy:     next_regs.second_index_register = next_tmp;
              op_swap_sp_hl: next_regs.third_general_pair    = tmp;
              op_swap_de_hl: begin
                next_regs.second_general_pair = regs.third_general_pair;
                next_regs.third_general_pair  = regs.second_general_pair;
              end
              op_swap_af: begin
                next_regs.accum_flags_pair           = regs.alternate_accum_flags_pair;
                next_regs.alternate_accum_flags_pair = regs.accum_flags_pair;
              end
              op_bank_swap: begin
                next_regs.first_general_pair    = regs.alternate_first_pair;
                next_regs.alternate_first_pair  = regs.first_general_pair;
                next_regs.second_general_pair   = regs.alternate_second_pair;
                next_regs.alternate_second_pair = regs.second_general_pair;
                next_regs.third_general_pair    = regs.alternate_third_pair;
                next_regs.alternate_third_pair  = regs.third_general_pair;
              end
              default: next_regs = next_regs;
            endcase
          end else begin
            next_mcyc = mcyc + 3'd1;
            next_tst  = 3'd0;
            // The address uses the pointer as it stands after this cycle's step.
            next_mem.addr  = next_regs.stack_pointer + {{14{acc_next.ofs[1]}}, acc_next.ofs};
            next_mem.wdata = acc_next.hi ? src[15:8] : src[7:0];
            next_mem.rd    = acc_next.rd;
            next_mem.wr    = acc_next.wr;
          end
        end
      end
      default: next_state = st_idle;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= st_idle;
      op       <= op_none;
      pair_sel <= SEL_FIRST;
      mcyc     <= 3'd0;
      tst      <= 3'd0;
    end else begin
      state    <= next_state;
      op       <= next_op;
      pair_sel <= next_pair_sel;
      mcyc     <= next_mcyc;
      tst      <= next_tst;
    end
  end

  // ----------------------------------------------------------------
  // Register file and holding register
  // ----------------------------------------------------------------
  // A popped word waits in tmp, so no pair ever shows a half-loaded value.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmp  <= REG_RESET;
      regs <= '0;
    end else begin
      tmp  <= next_tmp;
      regs <= next_regs;
    end
  end

  // ----------------------------------------------------------------
  // Bus and status outputs
  // ----------------------------------------------------------------
  // Strobes are rebuilt at every machine-cycle boundary from the next access.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem  <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      mem  <= next_mem;
      busy <= next_busy;
      done <= next_done;
    end
  end

endmodule // stack_and_exchange_exec

// ---- verification/stack_mem.sv ----
/*
  Behavioural stack memory facing the execution unit's memory bus.
  Assumes one access at a time and that the bench preloads bytes directly.
*/
`timescale 1ns/1ps
module stack_mem
  import stack_exchange_pkg::*;
(
  // Bus
  input  wire logic     ref_clk,
  input  wire mem_req_t mem,
  output logic [7:0]    mem_rdata
);
  logic [7:0] ram [0:65535];
  logic [7:0] last = 8'h5a;
  // An idle bus shows the inverted last byte, so a late sample cannot pass.
  assign mem_rdata = mem.rd ? ram[mem.addr] : ~last;
  always @(posedge ref_clk) begin
    last <= mem_rdata;
    if (mem.wr) begin
      ram[mem.addr] <= mem.wdata;
    end
  end
endmodule // stack_mem

// ---- verification/stack_and_exchange_exec_asserts.sv ----
/*
  Checker for the stack and exchange execution unit.
  Assumes one clock state per ref_clk cycle; bound at the foot of this file.
*/
`timescale 1ns/1ps
module stack_and_exchange_exec_asserts
  import stack_exchange_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       start,
  input wire logic [7:0] prefix,
  input wire logic [7:0] opcode,
  input wire logic       load_en,
  input wire regs_t      load_value,
  input wire logic [7:0] mem_rdata,
  input wire mem_req_t   mem,
  input wire regs_t      regs,
  input wire logic       busy,
  input wire logic       done
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0]  lop;
  logic [7:0]  lpre;
  logic [7:0]  blen;
  logic [7:0]  rdc;
  logic [7:0]  wrc;
  logic [7:0]  rlo;
  logic [7:0]  rhi;
  logic [15:0] ssp;
  logic [15:0] lsrc;
  logic        exempt;

  function automatic logic [7:0] len_of(logic [7:0] op, logic [7:0] pre);
    if (pre == PREFIX_FIRST_INDEX || pre == PREFIX_SECOND_INDEX) begin
      return (op == OPC_PUSH_INDEX) ? 8'h0f : 8'h0e;
    end
    if ((op & PAIR_OP_MASK) == OPC_PUSH_PAIR) return 8'h0b;
    if ((op & PAIR_OP_MASK) == OPC_POP_PAIR) return 8'h0a;
    return (op == OPC_SWAP_SP_HL) ? 8'h13 : 8'h04;
  endfunction

  function automatic logic [15:0] src_of(regs_t r, logic [7:0] op, logic [7:0] pre);
    if (pre == PREFIX_FIRST_INDEX) return r.first_index_register;
    if (pre == PREFIX_SECOND_INDEX) return r.second_index_register;
    case (op[5:4])
      SEL_FIRST: return r.first_general_pair;
      SEL_SECOND: return r.second_general_pair;
      SEL_THIRD: return r.third_general_pair;
      default: return r.accum_flags_pair;
    endcase
  endfunction

  // Restoring the accumulator-flags pair from the stack rewrites the flags legitimately.
  assign exempt = lop == OPC_SWAP_AF || (lop == 8'hf1 && lpre != PREFIX_FIRST_INDEX
                  && lpre != PREFIX_SECOND_INDEX);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {lop, lpre, blen, rdc, wrc, rlo, rhi, ssp, lsrc} <= '0;
    end else if (start && !busy) begin
      {lop, lpre, blen, rdc, wrc} <= {opcode, prefix, 24'h000000};
      ssp <= regs.stack_pointer;
      lsrc <= src_of(regs, opcode, prefix);
    end else begin
      blen <= blen + 8'(busy);
      rdc <= rdc + 8'(mem.rd);
      wrc <= wrc + 8'(mem.wr);
      rlo <= (mem.rd && rdc < 8'h03) ? mem_rdata : rlo;
      rhi <= mem.rd ? mem_rdata : rhi;
    end
  end

  property p_length;
    $fell(busy) |-> blen == len_of(lop, lpre) && done;
  endproperty
  a_length: assert property (p_length)
    else $error("instruction length wrong");
  property p_sp;
    $fell(busy) |-> regs.stack_pointer == ((lop & PAIR_OP_MASK) == OPC_PUSH_PAIR ?
      ssp - 16'h0002 : (lop & PAIR_OP_MASK) == OPC_POP_PAIR ? ssp + 16'h0002 : ssp);
  endproperty
  a_sp: assert property (p_sp) else $error("final stack pointer wrong");
  property p_read;
    mem.rd |-> mem.addr == ssp + 16'(rdc >= 8'h03);
  endproperty
  a_read: assert property (p_read) else $error("read address wrong");
  property p_write;
    mem.wr |-> mem.addr == (lop == OPC_SWAP_SP_HL ? ssp + 16'h0001 : ssp - 16'h0001)
      - 16'(wrc >= 8'h03) && mem.wdata == (wrc >= 8'h03 ? lsrc[7:0] : lsrc[15:8]);
  endproperty
  a_write: assert property (p_write) else $error("write wrong");
  property p_load;
    $fell(busy) && ((lop & PAIR_OP_MASK) == OPC_POP_PAIR || lop == OPC_SWAP_SP_HL)
      |-> src_of(regs, lop, lpre) == {rhi, rlo};
  endproperty
  a_load: assert property (p_load) else $error("loaded pair wrong");
  property p_de_hl;
    $fell(busy) && lop == OPC_SWAP_DE_HL |-> regs.second_general_pair ==
      $past(regs.third_general_pair) && regs.third_general_pair == $past(regs.second_general_pair);
  endproperty
  a_de_hl: assert property (p_de_hl) else $error("pair swap wrong");
  property p_af;
    $fell(busy) && lop == OPC_SWAP_AF |->
      regs.accum_flags_pair == $past(regs.alternate_accum_flags_pair);
  endproperty
  a_af: assert property (p_af) else $error("accumulator swap wrong");
  property p_bank;
    $fell(busy) && lop == OPC_BANK_SWAP |-> regs.first_general_pair ==
      $past(regs.alternate_first_pair) && regs.alternate_third_pair == $past(regs.third_general_pair);
  endproperty
  a_bank: assert property (p_bank) else $error("bank swap wrong");
  property p_flags;
    busy && !exempt |=> $stable(regs.accum_flags_pair[7:0]);
  endproperty
  a_flags: assert property (p_flags) else $error("flags changed");

  c_ex_sp: cover property ($fell(busy) && lop == OPC_SWAP_SP_HL);
  c_write: cover property ($rose(mem.wr));
  c_back: cover property (start && done);
endmodule // stack_and_exchange_exec_asserts

bind stack_and_exchange_exec stack_and_exchange_exec_asserts u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .start(start), .prefix(prefix), .opcode(opcode),
  .load_en(load_en), .load_value(load_value), .mem_rdata(mem_rdata), .mem(mem),
  .regs(regs), .busy(busy), .done(done)
);

// ---- verification/stack_and_exchange_exec_tb.sv ----
/*
  Self-checking bench for the stack and exchange execution unit.
  Assumes the checker binds itself and the memory model answers in the cycle.
*/
`timescale 1ns/1ps
module stack_and_exchange_exec_tb
  import stack_exchange_pkg::*;
;
  localparam regs_t BASE = {16'h0b0c, 16'h0d0e, 16'h4142, 16'h9944, 16'h0988, 16'h9300,
                            16'h00e7, 16'h5900, 16'h2233, 16'h4174, 16'h1007};
  logic       ref_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       start = 1'b0;
  logic       load_en = 1'b0;
  logic [7:0] prefix = 8'h00;
  logic [7:0] opcode = 8'h00;
  logic [7:0] mem_rdata;
  regs_t      load_value = '0;
  regs_t      regs;
  regs_t      r;
  mem_req_t   mem;
  logic       busy;
  logic       done;
  int         error_cnt = 0;
  int         samples_checked = 0;

  always #10 ref_clk = ~ref_clk;

  stack_and_exchange_exec u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .start(start),
    .prefix(prefix), .opcode(opcode), .load_en(load_en), .load_value(load_value),
    .mem_rdata(mem_rdata), .mem(mem), .regs(regs), .busy(busy), .done(done));
  stack_mem u_mem (.ref_clk(ref_clk), .mem(mem), .mem_rdata(mem_rdata));

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] pair(regs_t x, int q);
    case (q)
      0: return x.first_general_pair;
      1: return x.second_general_pair;
      2: return x.third_general_pair;
      default: return x.accum_flags_pair;
    endcase
  endfunction

  // Issues at the current falling edge, so calls in a row run back to back.
  task automatic run(input logic [7:0] pre, input logic [7:0] op, input logic [15:0] len);
    int n;
    n = 0;
    prefix = pre;
    opcode = op;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    while (busy === 1'b1 && n < 40) begin
      n++;
      @(negedge ref_clk);
    end
    chk("busy cycles", 16'(n), len);
    chk("done", {15'h0000, done}, {15'h0000, len != 16'h0000});
  endtask

  task automatic ld(input regs_t v);
    load_value = v;
    load_en = 1'b1;
    @(negedge ref_clk);
    load_en = 1'b0;
  endtask

  task automatic t_pairs();
    logic [15:0] v;
    for (int q = 0; q < 4; q++) begin
      r = BASE;
      ld(r);
      v = pair(r, q);
      run(8'h00, OPC_PUSH_PAIR | 8'(q << 4), 16'd11);
      chk("push hi", {8'h00, u_mem.ram[16'h1006]}, {8'h00, v[15:8]});
      chk("push lo", {8'h00, u_mem.ram[16'h1005]}, {8'h00, v[7:0]});
      chk("push sp", regs.stack_pointer, 16'h1005);
      r.stack_pointer = 16'hffff;
      ld(r);
      u_mem.ram[16'hffff] = 8'h55;
      u_mem.ram[16'h0000] = 8'h33 + 8'(q);
      run(8'h00, OPC_POP_PAIR | 8'(q << 4), 16'd10);
      chk("pop pair", pair(regs, q), {8'h33 + 8'(q), 8'h55});
      chk("pop sp", regs.stack_pointer, 16'h0001);
    end
  endtask

  task automatic t_index();
    logic [7:0]  p;
    logic [15:0] v;
    for (int i = 0; i < 2; i++) begin
      p = i ? PREFIX_SECOND_INDEX : PREFIX_FIRST_INDEX;
      r = BASE;
      r.stack_pointer = 16'h0001;
      ld(r);
      v = i ? r.second_index_register : r.first_index_register;
      run(p, OPC_PUSH_INDEX, 16'd15);
      chk("index hi", {8'h00, u_mem.ram[16'h0000]}, {8'h00, v[15:8]});
      chk("index lo", {8'h00, u_mem.ram[16'hffff]}, {8'h00, v[7:0]});
      chk("index sp", regs.stack_pointer, 16'hffff);
      r.first_index_register = 16'h0000;
      r.second_index_register = 16'h0000;
      r.stack_pointer = 16'hffff;
      ld(r);
      run(p, OPC_POP_INDEX, 16'd14);
      chk("index pop", i ? regs.second_index_register : regs.first_index_register, v);
      chk("index pop sp", regs.stack_pointer, 16'h0001);
    end
  endtask

  task automatic t_swaps();
    r = BASE;
    ld(r);
    run(8'h00, 8'h00, 16'd0);
    run(8'h00, OPC_SWAP_DE_HL, 16'd4);
    chk("second pair", regs.second_general_pair, r.third_general_pair);
    chk("third pair", regs.third_general_pair, r.second_general_pair);
    run(8'h00, OPC_SWAP_AF, 16'd4);
    chk("accum pair", regs.accum_flags_pair, r.alternate_accum_flags_pair);
    chk("alt accum", regs.alternate_accum_flags_pair, r.accum_flags_pair);
    run(8'h00, OPC_BANK_SWAP, 16'd4);
    chk("first pair", regs.first_general_pair, r.alternate_first_pair);
    chk("third pair", regs.third_general_pair, r.alternate_third_pair);
    chk("alt second", regs.alternate_second_pair, r.third_general_pair);
    chk("alt first", regs.alternate_first_pair, r.first_general_pair);
    chk("bank second", regs.second_general_pair, r.alternate_second_pair);
    chk("alt third", regs.alternate_third_pair, r.second_general_pair);
  endtask

  task automatic t_exsp();
    r = BASE;
    r.third_general_pair = 16'h7012;
    r.stack_pointer = 16'h8856;
    ld(r);
    u_mem.ram[16'h8856] = 8'h11;
    u_mem.ram[16'h8857] = 8'h22;
    run(8'h00, OPC_SWAP_SP_HL, 16'd19);
    chk("third pair", regs.third_general_pair, 16'h2211);
    chk("stack lo", {8'h00, u_mem.ram[16'h8856]}, 16'h0012);
    chk("stack hi", {8'h00, u_mem.ram[16'h8857]}, 16'h0070);
    chk("stack sp", regs.stack_pointer, 16'h8856);
    chk("flags", regs.accum_flags_pair, r.accum_flags_pair);
  endtask

  // A start or a preload raised while busy must be ignored.
  task automatic t_refuse();
    r = BASE;
    ld(r);
    prefix = 8'h00;
    opcode = OPC_PUSH_PAIR;
    start = 1'b1;
    @(negedge ref_clk);
    opcode = OPC_SWAP_DE_HL;
    load_value = '0;
    load_en = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    load_en = 1'b0;
    repeat (12) @(negedge ref_clk);
    chk("refused busy", {15'h0000, busy}, 16'h0000);
    chk("refused sp", regs.stack_pointer, 16'h1005);
    chk("refused swap", regs.second_general_pair, r.second_general_pair);
    chk("refused load", regs.first_general_pair, r.first_general_pair);
  endtask

  initial begin
    repeat (5) @(negedge ref_clk);
    chk("reset sp", regs.stack_pointer, 16'h0000);
    rst_n = 1'b1;
    @(negedge ref_clk);
    t_pairs();
    t_index();
    t_swaps();
    t_exsp();
    t_refuse();
    conclude();
  end

  // The whole run needs about 225 cycles; allow a wide margin.
  initial begin
    #(20 * 2000);
    error_cnt++;
    conclude();
  end
endmodule // stack_and_exchange_exec_tb
